// File: pll_lock_control.v
`include "pll_lock_control_regs.vh"

module pll_lock_control #(
    parameter CNT_W = `LOCKUP_CNT_W
) (
    input  wire        core_clk_in,
    input  wire        reset_n_in,
    input  wire [31:0] addr_in,
    input  wire [7:0]  wdata_in,
    input  wire        wr_in,
    input  wire        rd_in,
    input  wire        bit_access_in,
    output reg  [7:0]  rdata_out,
    input  wire        light_standby_in,
    input  wire        deep_standby_in,
    input  wire        stop_mode_in,
    input  wire        standby_release_in,
    input  wire        stab_timer_ovf_in,
    input  wire        main_osc_stop_in,
    input  wire        subclock_select_in,
    output wire        pll_running_out,
    output wire        pll_mode_out,
    output wire [2:0]  clock_multiplier_out,
    output wire [7:0]  divider_control_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // register state

    reg [7:0]       ctrl_r;
    reg [7:0]       divider_r;
    reg             unlocked_r;
    reg [1:0]       lockup_sel_r;
    reg             protect_armed_r;
    reg [CNT_W-1:0] lockup_cnt_r;
    reg             lockup_busy_r;
    reg             in_standby_r;
    reg             standby_was_stop_r;
    reg             standby_pll_on_r;
    reg             wait_stab_r;
    reg             reset_wait_r;

    wire pll_en   = ctrl_r[`PLL_ENABLE_BIT];
    wire wr_ctrl  = wr_in && (addr_in == `PLL_CONTROL_ADDR);
    wire wr_div   = wr_in && (addr_in == `DIVIDER_CONTROL_ADDR);
    wire wr_lsel  = wr_in && (addr_in == `LOCKUP_TIME_SELECT_ADDR);
    wire wr_prot  = wr_in && (addr_in == `PROTECT_CMD_ADDR);
    wire standby_entry = (deep_standby_in || stop_mode_in) && !in_standby_r;
    // full reset byte, only the low two bits are stored
    wire [7:0] lockup_reset = `LOCKUP_TIME_RESET;

    function [CNT_W-1:0] lockup_limit;
        input [1:0] sel;
        begin
            lockup_limit = {{(CNT_W-1){1'b0}}, 1'b1} << (`LOCKUP_BASE_EXP + sel);
        end
    endfunction

    assign pll_running_out      = pll_en && !in_standby_r;
    // x4 clock only in pll mode
    assign pll_mode_out         = ctrl_r[`PLL_MODE_SELECT_BIT] && pll_running_out;
    assign clock_multiplier_out = pll_mode_out ? 3'd`PLL_MULTIPLIER : 3'd1;
    assign divider_control_out  = divider_r;

    ////////////////////////////////////////////////////////////////////////////////
    // control registers

    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            ctrl_r          <= `PLL_CONTROL_RESET;
            divider_r       <= `DIVIDER_CONTROL_RESET;
            lockup_sel_r    <= lockup_reset[1:0];
            protect_armed_r <= 1'b0;
        end else begin
            // any access after the protect command other than another protect command disarms it, so stray writes fail
            if (wr_in || rd_in) begin
                protect_armed_r <= wr_prot;
            end
            if (wr_ctrl) begin
                if (!wdata_in[`PLL_ENABLE_BIT]) begin
                    ctrl_r <= 8'h00;
                end else begin
                    ctrl_r <= {6'b0, wdata_in[`PLL_MODE_SELECT_BIT] & ~unlocked_r, 1'b1};
                end
            end
            if (wr_div && protect_armed_r) begin
                divider_r <= wdata_in;
            end
            if (wr_lsel && !bit_access_in) begin
                lockup_sel_r <= wdata_in[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // lockup timer and standby tracking

    wire enable_rise = wr_ctrl && wdata_in[`PLL_ENABLE_BIT] && !pll_en;

    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            lockup_cnt_r  <= {CNT_W{1'b0}};
            lockup_busy_r <= 1'b0;
        end else if (enable_rise) begin
            lockup_cnt_r  <= {CNT_W{1'b0}};
            lockup_busy_r <= 1'b1;
        end else if (lockup_busy_r) begin
            if (!pll_en || standby_entry) begin
                lockup_busy_r <= 1'b0;
            end else if (lockup_cnt_r == lockup_limit(lockup_sel_r) - 1'b1) begin
                lockup_busy_r <= 1'b0;
            end else begin
                lockup_cnt_r <= lockup_cnt_r + 1'b1;
            end
        end
    end

    wire lockup_done = lockup_busy_r && pll_en && !standby_entry &&
                       (lockup_cnt_r == lockup_limit(lockup_sel_r) - 1'b1);

    // light standby is not tracked, pll keeps running
    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            in_standby_r       <= 1'b0;
            standby_was_stop_r <= 1'b0;
            standby_pll_on_r   <= 1'b0;
            wait_stab_r        <= 1'b0;
        end else if (standby_entry) begin
            in_standby_r       <= 1'b1;
            standby_was_stop_r <= stop_mode_in;
            standby_pll_on_r   <= pll_en;
        end else if (in_standby_r && standby_release_in) begin
            in_standby_r <= 1'b0;
            wait_stab_r  <= standby_pll_on_r;
        end else if (wait_stab_r && stab_timer_ovf_in) begin
            wait_stab_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // unlocked flag

    wire set_unlock = standby_entry ||
                      (wr_ctrl && !wdata_in[`PLL_ENABLE_BIT]) ||
                      (main_osc_stop_in && subclock_select_in);

    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            unlocked_r   <= 1'b1;
            reset_wait_r <= 1'b1;
        end else begin
            if (reset_wait_r && stab_timer_ovf_in) begin
                reset_wait_r <= 1'b0;
            end
            if (set_unlock) begin
                unlocked_r <= 1'b1;
            end else if (reset_wait_r && stab_timer_ovf_in) begin
                unlocked_r <= 1'b0;
            end else if (wait_stab_r && stab_timer_ovf_in) begin
                unlocked_r <= 1'b0;
            end else if (lockup_done) begin
                unlocked_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read port

    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            case (addr_in)
                `PLL_CONTROL_ADDR:        rdata_out <= ctrl_r;
                `DIVIDER_CONTROL_ADDR:    rdata_out <= divider_r;
                `LOCK_STATUS_ADDR:        rdata_out <= {7'b0, unlocked_r};
                `LOCKUP_TIME_SELECT_ADDR: rdata_out <= bit_access_in ? 8'h00 : {6'b0, lockup_sel_r};
                `PLL_STATUS_ADDR:         rdata_out <= {5'b0, lockup_busy_r, in_standby_r, pll_running_out};
                default:                  rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

endmodule // pll_lock_control

// File: pll_lock_control_regs.vh
`ifndef PLL_LOCK_CONTROL_REGS_VH
`define PLL_LOCK_CONTROL_REGS_VH

// register byte addresses on the plain register port
`define PLL_CONTROL_ADDR        32'hFFFF_F820
`define DIVIDER_CONTROL_ADDR    32'hFFFF_F822
`define LOCK_STATUS_ADDR        32'hFFFF_F824
`define LOCKUP_TIME_SELECT_ADDR 32'hFFFF_F826
`define PROTECT_CMD_ADDR        32'hFFFF_F830
`define PLL_STATUS_ADDR         32'hFFFF_F834

// reset values; LOCK_STATUS_RESET is unused, the lock flag resets to 1
`define PLL_CONTROL_RESET       8'h01
`define DIVIDER_CONTROL_RESET   8'h0A
`define LOCK_STATUS_RESET       8'h00
`define LOCKUP_TIME_RESET       8'h03

// field positions
`define PLL_ENABLE_BIT          0
`define PLL_MODE_SELECT_BIT     1
`define LOCK_FLAG_BIT           0

// lockup time exponents: code 00 gives 2^10 oscillator periods
`define LOCKUP_BASE_EXP         10
`define LOCKUP_CNT_W            14

// oscillator frequency multiplier in pll mode
`define PLL_MULTIPLIER          4

`endif

// File: pll_lock_control_sva.sv
module pll_lock_control_sva #(parameter CNT_W = 14) (
    input wire logic        core_clk_in, reset_n_in, wr_in, rd_in, pll_running_out, pll_mode_out,
    input wire logic        deep_standby_in, stop_mode_in,
    input wire logic [31:0] addr_in,
    input wire logic [7:0]  wdata_in, rdata_out, divider_control_out,
    input wire logic [2:0]  clock_multiplier_out);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    // idle cycles keep the protect command armed, only a new access replaces it
    logic armed_q;
    always @(posedge core_clk_in) begin
        if (!reset_n_in) armed_q <= 1'b0;
        else if (wr_in || rd_in) armed_q <= wr_in && addr_in == 32'hffff_f830;
    end
    sequence s_div_wr; wr_in && addr_in == 32'hffff_f822; endsequence
    chk_div_protect: assert property (s_div_wr and !armed_q |=> $stable(divider_control_out)) else $error("div");
    chk_div_init: assert property (disable iff (1'b0) !reset_n_in |=> divider_control_out == 8'h0a)
        else $error("divider reset");
    chk_clear_mode: assert property (wr_in && addr_in == 32'hffff_f820 && !wdata_in[0] |=> !pll_mode_out)
        else $error("mode kept");
    chk_mode_run: assert property (pll_mode_out |-> pll_running_out) else $error("mode idle");
    chk_mult_map: assert property (clock_multiplier_out == (pll_mode_out ? 3'h4 : 3'h1)) else $error("mult");
    chk_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00) else $error("rdata");
    chk_status_hi: assert property (rd_in && addr_in == 32'hffff_f824 |=> rdata_out[7:1] == 7'h00) else $error("st");
    chk_halt_sleep: assert property ((deep_standby_in || stop_mode_in) [*2] |-> !pll_running_out) else $error("h");
endmodule // pll_lock_control_sva
////////////////////////////////////////////////////////////
bind pll_lock_control pll_lock_control_sva #(.CNT_W(CNT_W)) u_sva (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .wr_in(wr_in), .rd_in(rd_in), .pll_running_out(pll_running_out), .pll_mode_out(pll_mode_out), .addr_in(addr_in),
    .deep_standby_in(deep_standby_in), .stop_mode_in(stop_mode_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
    .divider_control_out(divider_control_out), .clock_multiplier_out(clock_multiplier_out));

// File: osc_standby_model.sv
module osc_standby_model #(parameter int STAB = 20) (
    input  wire logic       core_clk_in, reset_n_in,
    input  wire logic [1:0] cmd_in,
    output logic            deep_standby_out, stop_mode_out, release_out, stab_ovf_out);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cmd_q;
    int         cnt; // fresh count after reset and on every wake-up
    always @(posedge core_clk_in) begin
        cmd_q            <= reset_n_in ? cmd_in : 2'h0;
        deep_standby_out <= reset_n_in && cmd_in == 2'h1;
        stop_mode_out    <= reset_n_in && cmd_in == 2'h2;
        release_out      <= reset_n_in && cmd_q != 2'h0 && cmd_in == 2'h0;
        stab_ovf_out     <= cnt == 1;
        cnt              <= (!reset_n_in || (cmd_q != 2'h0 && cmd_in == 2'h0)) ? STAB : (cnt > 0 ? cnt - 1 : 0);
    end
endmodule // osc_standby_model

// File: test_pll_lock_control.sv
module test_pll_lock_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] ctl = 32'hffff_f820, dvr = 32'hffff_f822, lck = 32'hffff_f824, sel = 32'hffff_f826;
    localparam logic [31:0] prt = 32'hffff_f830, sts = 32'hffff_f834;
    logic        clk = 0, rst_n = 0, wr = 0, rd = 0, bacc = 0, light = 0, rd_q = 0, mosc = 0, subc = 0;
    logic [31:0] addr = 0;
    logic [7:0]  wdata = 0, cmd = 0, q[$];
    wire         deep, stop, rel, ovf, run;
    wire  [7:0]  rdata;
    wire  [2:0]  mult;
    int          fails = 0, n_checks = 0, seed = 32'h989e, k;
    pll_lock_control #(.CNT_W(14)) dut_u (.core_clk_in(clk), .reset_n_in(rst_n), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .bit_access_in(bacc), .rdata_out(rdata), .light_standby_in(light), .deep_standby_in(deep),
        .stop_mode_in(stop), .standby_release_in(rel), .stab_timer_ovf_in(ovf), .main_osc_stop_in(mosc),
        .subclock_select_in(subc), .pll_running_out(run), .pll_mode_out(), .clock_multiplier_out(mult),
        .divider_control_out());
    osc_standby_model #(.STAB(20)) osc_u (.core_clk_in(clk), .reset_n_in(rst_n), .cmd_in(cmd[1:0]),
        .deep_standby_out(deep), .stop_mode_out(stop), .release_out(rel), .stab_ovf_out(ovf));
    initial forever #10 clk = ~clk;
    task automatic end_of_test();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_checks++;
        fails += int'(s !== e);
        if (s !== e) $display("Error at %0t: seen %h expected %h", $time, s, e);
    endtask
    // one access per call, idle cycle between calls
    task automatic acc(input logic w, input logic [31:0] a, input logic [7:0] v, input logic b = 1'b0);
        @(posedge clk);
        {wr, rd, bacc, addr, wdata} <= {w, !w, b, a, v};
        if (!w) q.push_back(v);
        @(posedge clk);
        {wr, rd, bacc} <= 3'h0;
    endtask
    task automatic wovf();
        for (int j = 0; j < 100 && ovf !== 1'b1; j++) @(posedge clk);
        if (ovf !== 1'b1) begin
            fails++;
            end_of_test();
        end
    endtask
    always @(posedge clk) begin
        if (rd_q) chk(rdata, q.pop_front());
        rd_q <= rd;
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        acc(0, ctl, 8'h01);
        acc(0, dvr, 8'h0a);
        acc(0, sel, 8'h03);
        acc(0, lck, 8'h01);
        acc(1, ctl, 8'h03);
        acc(0, ctl, 8'h01);
        wovf();
        acc(0, lck, 8'h00);
        acc(1, dvr, 8'($random(seed)) | 8'h80);
        acc(0, dvr, 8'h0a);
        acc(1, prt, 8'h00);
        acc(1, dvr, 8'h0a);
        acc(0, dvr, 8'h0a);
        acc(1, sel, 8'h00, 1'b1);
        acc(0, sel, 8'h03);
        acc(1, sel, 8'h00);
        acc(0, sel, 8'h00);
        @(posedge clk) light <= 1'b1;
        acc(1, ctl, 8'h03);
        #1 chk({5'h00, mult}, 8'h04);
        chk({7'h00, run}, 8'h01);
        for (k = 1; k < 3; k++) begin
            @(posedge clk) cmd <= k[7:0];
            repeat (3) @(posedge clk);
            acc(0, lck, 8'h01);
            acc(0, sts, 8'h02);
            @(posedge clk) cmd <= 8'h00;
            wovf();
            acc(0, lck, 8'h00);
            acc(0, ctl, 8'h03);
        end
        acc(1, ctl, 8'h01);
        repeat (8) @(posedge clk);
        acc(1, ctl, 8'h00);
        acc(0, lck, 8'h01);
        acc(1, ctl, 8'h01);
        repeat (1000) @(posedge clk);
        acc(0, lck, 8'h01);
        repeat (40) @(posedge clk);
        acc(0, lck, 8'h00);
        @(posedge clk) {mosc, subc} <= 2'b11;
        @(posedge clk) {mosc, subc} <= 2'b00;
        acc(0, lck, 8'h01);
        repeat (2) @(posedge clk);
        end_of_test();
    end
endmodule // test_pll_lock_control
